//--- rtl/shp_host_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "shp_params.svh"

module shp_host_port #(
  parameter int SYNC_STAGES = `SHP_SYNC_STAGES,
  parameter int RECOVERY_CYC = `SHP_RECOVERY_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic chip_sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic data_sel,
  input wire logic chan_a,
  input wire logic irq_ack_n,
  input wire logic enhanced_mode,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] pending_src,
  input wire logic [7:0] vector_status,
  input wire logic [7:0] status_a,
  input wire logic [7:0] status_b,
  input wire logic [7:0] rx_data_a,
  input wire logic [7:0] rx_data_b,
  input wire shp_pkg::shp_frame_s frame_a,
  input wire shp_pkg::shp_frame_s frame_b,
  output logic [7:0] pending_flags,
  output logic [7:0] tx_data,
  output logic tx_write,
  output logic tx_chan_a,
  output logic rx_read,
  output logic rx_chan_a,
  output logic hw_reset,
  output logic [7:0] shared_vector_reg,
  output logic [7:0] master_irq_control,
  output logic [7:0] frame_option_a,
  output logic [7:0] frame_option_b,
  output logic [16*8-1:0] wregs_a,
  output logic [16*8-1:0] wregs_b,
  output logic busy
);
  // recovery counter width, just enough to hold RECOVERY_CYC
  localparam int RW = $clog2(RECOVERY_CYC + 1);

  // synchroniser chains; first stage read only by the next stage
  logic [SYNC_STAGES-1:0] rd_sy_q, wr_sy_q, cs_sy_q, ack_sy_q;
  logic rd_s, wr_s, cs_s, ack_s;
  shp_pkg::shp_state_e state_q;
  shp_pkg::shp_access_s acc_q;
  logic [RW-1:0] rec_q;
  logic [2:0] pointer_bits;
  logic point_high_q;
  logic ack_seen_high_q;
  // one write register array per channel, indexed like the pointer
  logic [7:0] wreg_a [16];
  logic [7:0] wreg_b [16];
  logic [7:0] rd_word;
  logic [3:0] idx;
  logic start;
  logic opt_sel_a;
  logic opt_sel_b;

  function automatic logic [7:0] pick(input logic sel, input logic [7:0] a, input logic [7:0] b);
    pick = sel ? a : b;
  endfunction

  // the one edge at which a taken access acts on registers and strobes
  function automatic logic op_edge(input shp_pkg::shp_state_e st, input logic [RW-1:0] rc);
    op_edge = (st == shp_pkg::SHP_BUSY) && (rc == RW'(RECOVERY_CYC - 1));
  endfunction

  // sync the strobes, chip select and acknowledge into the master clock domain
  // clk_en low freezes every register, the sync chains included
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_sy_q <= '1;
      wr_sy_q <= '1;
      cs_sy_q <= '1;
      ack_sy_q <= '1;
    end else if (clk_en) begin
      rd_sy_q <= {rd_sy_q[SYNC_STAGES-2:0], rd_n};
      wr_sy_q <= {wr_sy_q[SYNC_STAGES-2:0], wr_n};
      cs_sy_q <= {cs_sy_q[SYNC_STAGES-2:0], chip_sel_n};
      ack_sy_q <= {ack_sy_q[SYNC_STAGES-2:0], irq_ack_n};
    end
  end
  // only the last stage of each chain feeds the logic
  assign rd_s = rd_sy_q[SYNC_STAGES-1];
  assign wr_s = wr_sy_q[SYNC_STAGES-1];
  assign cs_s = cs_sy_q[SYNC_STAGES-1];
  assign ack_s = ack_sy_q[SYNC_STAGES-1];

  // acknowledge must be seen high on an earlier edge before a cycle counts
  // resets low so the first edge after reset cannot pass an unseen acknowledge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_seen_high_q <= 1'b0;
    end else if (clk_en) begin
      ack_seen_high_q <= ack_s;
    end
  end

  // strobes are ignored without chip select; both strobes means reset
  // reset level is combinational; the sync chain already filters glitches
  assign hw_reset = !cs_s && !rd_s && !wr_s;
  assign start = (state_q == shp_pkg::SHP_IDLE) && !cs_s && (rd_s ^ wr_s)
                 && ack_s && ack_seen_high_q;
  assign busy = state_q != shp_pkg::SHP_IDLE;
  // the host keeps the selects steady while the strobe is low, so the
  // raw select pins are captured into acc_q at start without their own chain
  assign idx = acc_q.data_sel ? `SHP_IDX_RXBUF : {point_high_q, pointer_bits};
  // option register shadows index 7 only in enhanced mode while its enable bit is set
  assign opt_sel_a = idx == `SHP_IDX_OPT_ALT && enhanced_mode && wreg_a[`SHP_IDX_OPT][0] && acc_q.chan_a;
  assign opt_sel_b = idx == `SHP_IDX_OPT_ALT && enhanced_mode && wreg_b[`SHP_IDX_OPT][0] && !acc_q.chan_a;

  // access sequencer with recovery counter; other devices' cycles never reach it
  // the sync delay sits ahead of the count, so spacing is never short
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= shp_pkg::SHP_IDLE;
      rec_q <= '0;
      acc_q <= '0;
    end else if (clk_en) begin
      unique case (state_q)
        shp_pkg::SHP_IDLE: begin
          if (start) begin
            acc_q <= '{data_sel: data_sel, chan_a: chan_a, is_write: !wr_s};
            rec_q <= RW'(RECOVERY_CYC - 1);
            state_q <= shp_pkg::SHP_BUSY;
          end
        end
        shp_pkg::SHP_BUSY: begin
          if (rec_q != '0) begin
            rec_q <= rec_q - RW'(1);
          end else begin
            state_q <= shp_pkg::SHP_WAIT_END;
          end
        end
        shp_pkg::SHP_WAIT_END: begin
          // recovery stalls only on our own strobe; foreign bus cycles have cs high
          if (cs_s || (rd_s && wr_s)) begin
            state_q <= shp_pkg::SHP_IDLE;
          end
        end
        // the spare state code falls back to idle rather than hanging
        default: begin
          state_q <= shp_pkg::SHP_IDLE;
        end
      endcase
    end
  end

  // pointer bits: set by command writes, cleared after a pointed access
  // a hardware reset in the same cycle beats a command write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pointer_bits <= '0;
      point_high_q <= 1'b0;
    end else if (clk_en) begin
      if (hw_reset) begin
        pointer_bits <= '0;
        point_high_q <= 1'b0;
      end else if (op_edge(state_q, rec_q) && !acc_q.data_sel) begin
        if (acc_q.is_write && idx == `SHP_IDX_CMD) begin
          pointer_bits <= data_in[2:0];
          point_high_q <= data_in[5:`SHP_CMD_LSB] == `SHP_CMD_POINT_HIGH;
        end else begin
          pointer_bits <= '0;
          point_high_q <= 1'b0;
        end
      end
    end
  end

  // write register file; vector and master control are single shared copies
  // only the option copy is diverted; plain index 7 keeps its value then
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) begin
        wreg_a[i] <= `SHP_RESET_VAL;
        wreg_b[i] <= `SHP_RESET_VAL;
      end
      shared_vector_reg <= `SHP_RESET_VAL;
      master_irq_control <= `SHP_RESET_VAL;
      frame_option_a <= `SHP_RESET_VAL;
      frame_option_b <= `SHP_RESET_VAL;
    end else if (clk_en && op_edge(state_q, rec_q) && acc_q.is_write) begin
      if (idx == `SHP_IDX_VEC) begin
        shared_vector_reg <= data_in;
      end else if (idx == `SHP_IDX_MIC) begin
        master_irq_control <= data_in;
      end else if (opt_sel_a) begin
        frame_option_a <= data_in;
      end else if (opt_sel_b) begin
        frame_option_b <= data_in;
      end else if (acc_q.chan_a) begin
        wreg_a[idx] <= data_in;
      end else begin
        wreg_b[idx] <= data_in;
      end
    end
  end

  // flatten the arrays so the outputs stay plain packed ports
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      wregs_a[i*8 +: 8] = wreg_a[i];
      wregs_b[i*8 +: 8] = wreg_b[i];
    end
  end

  // buffer strobes toward the channels, one cycle each
  // tx_data keeps its last byte between pulses; only the strobe qualifies it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_write <= 1'b0;
      rx_read <= 1'b0;
      tx_data <= '0;
      tx_chan_a <= 1'b0;
      rx_chan_a <= 1'b0;
    end else if (clk_en) begin
      tx_write <= 1'b0;
      rx_read <= 1'b0;
      if (op_edge(state_q, rec_q) && idx == `SHP_IDX_RXBUF) begin
        tx_write <= acc_q.is_write;
        rx_read <= !acc_q.is_write;
        tx_data <= data_in;
        tx_chan_a <= acc_q.chan_a;
        rx_chan_a <= acc_q.chan_a;
      end
    end
  end

  // pending flags run off the master clock, frozen while pointed at them or at the vector register
  // freezing stops a readback tearing, but delays new requests if left pointed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pending_flags <= '0;
    end else if (clk_en && !(idx == `SHP_IDX_VEC || idx == `SHP_IDX_PEND)) begin
      pending_flags <= pending_src;
    end
  end

  // read multiplexer
  // pending bits through channel B read as zero, not as the flags
  always_comb begin
    rd_word = '0;
    unique case (idx)
      `SHP_IDX_VEC: rd_word = acc_q.chan_a ? shared_vector_reg : vector_status;
      `SHP_IDX_PEND: rd_word = acc_q.chan_a ? pending_flags : 8'h00;
      `SHP_IDX_CNT_LO: rd_word = enhanced_mode ? pick(acc_q.chan_a, frame_a.count[7:0], frame_b.count[7:0])
                                               : pick(acc_q.chan_a, status_a, status_b);
      `SHP_IDX_CNT_HI: rd_word = enhanced_mode ? pick(acc_q.chan_a, {frame_a.status, frame_a.count[13:8]},
                                                      {frame_b.status, frame_b.count[13:8]})
                                               : pick(acc_q.chan_a, status_a, status_b);
      `SHP_IDX_RXBUF: rd_word = pick(acc_q.chan_a, rx_data_a, rx_data_b);
      `SHP_IDX_BAUD_LO: rd_word = pick(acc_q.chan_a, wreg_a[`SHP_IDX_BAUD_LO], wreg_b[`SHP_IDX_BAUD_LO]);
      `SHP_IDX_BAUD_HI: rd_word = pick(acc_q.chan_a, wreg_a[`SHP_IDX_BAUD_HI], wreg_b[`SHP_IDX_BAUD_HI]);
      default: rd_word = pick(acc_q.chan_a, status_a, status_b);
    endcase
  end

  // read data registered at operation start, driven while strobe lasts
  // held until the next access, so a slow host still reads a stable byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_out <= '0;
    end else if (clk_en && op_edge(state_q, rec_q)) begin
      data_out <= rd_word;
    end
  end

  // bus drive follows the raw pins so turnaround is not delayed by sync
  // vector drive in an acknowledge cycle is not part of this block
  assign data_oe = !chip_sel_n && !rd_n && wr_n && irq_ack_n;
endmodule
`default_nettype wire

//--- rtl/shp_params.svh
`ifndef SHP_PARAMS_SVH
`define SHP_PARAMS_SVH
// register indices after pointing
`define SHP_IDX_CMD 4'h0
`define SHP_IDX_VEC 4'h2
`define SHP_IDX_PEND 4'h3
`define SHP_IDX_CNT_LO 4'h6
`define SHP_IDX_CNT_HI 4'h7
`define SHP_IDX_RXBUF 4'h8
`define SHP_IDX_MIC 4'h9
`define SHP_IDX_BAUD_LO 4'hc
`define SHP_IDX_BAUD_HI 4'hd
`define SHP_IDX_OPT 4'hf
`define SHP_IDX_OPT_ALT 4'h7
// command field: point high code in bits 5..3
`define SHP_CMD_LSB 3
`define SHP_CMD_POINT_HIGH 3'h1
// recovery interval, in master-clock cycles (enhanced variant, rounded up)
`define SHP_RECOVERY_CYC 4
`define SHP_RECOVERY_OLD_CYC 4
`define SHP_SYNC_STAGES 2
`define SHP_RESET_VAL 8'h00
`endif

//--- rtl/shp_pkg.sv
package shp_pkg;
  typedef enum logic [1:0] {
    SHP_IDLE,
    SHP_BUSY,
    SHP_WAIT_END
  } shp_state_e;

  typedef struct packed {
    logic data_sel;
    logic chan_a;
    logic is_write;
  } shp_access_s;

  typedef struct packed {
    logic [13:0] count;
    logic [1:0] status;
  } shp_frame_s;
endpackage

//--- testbench/shp_host_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module shp_host_port_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic chip_sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic irq_ack_n,
  input wire logic data_oe,
  input wire logic tx_write,
  input wire logic rx_read,
  input wire logic hw_reset,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // bus drivers follow the raw pins, no synchroniser delay
  oe_follow_a:
    assert property (data_oe == (!chip_sel_n && !rd_n && wr_n && irq_ack_n)) else $error("bus enable wrong");
  // a start needs chip select seen low through the sync chain
  cs_gate_a:
    assert property ($rose(busy) |-> !$past(chip_sel_n, 3))
    else $error("start without chip select");
  ack_gate_a:
    assert property ($rose(busy) |-> $past(irq_ack_n, 3) && $past(irq_ack_n, 4)) else $error("start during ack");
  recovery_len_a:
    assert property ($rose(busy) |=> busy [*3]) else $error("recovery too short");
  tx_pulse_a:
    assert property (tx_write |=> !tx_write) else $error("tx pulse too long");
  rx_pulse_a:
    assert property (rx_read |=> !rx_read) else $error("rx pulse too long");
  own_effect_a:
    assert property (tx_write || rx_read |-> busy) else $error("effect outside access");
  hw_reset_src_a:
    assert property (hw_reset |-> !$past(rd_n, 2) && !$past(wr_n, 2) && !$past(chip_sel_n, 2))
    else $error("reset without both strobes");
  start_not_reset_a:
    assert property ($rose(busy) |-> !$past(hw_reset)) else $error("start during strobe reset");
  op_timing_a:
    assert property (tx_write || rx_read |-> $past(busy) && !$past(busy, 2)) else $error("effect at wrong cycle");
endmodule
bind shp_host_port shp_host_port_sva u_sva (.clk(clk), .resetn(resetn), .chip_sel_n(chip_sel_n), .rd_n(rd_n),
  .wr_n(wr_n), .irq_ack_n(irq_ack_n), .data_oe(data_oe), .tx_write(tx_write), .rx_read(rx_read),
  .hw_reset(hw_reset), .busy(busy));
`default_nettype wire

//--- testbench/shp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module shp_host_model (
  input wire logic clk,
  input wire logic [7:0] data_out,
  output logic chip_sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic data_sel,
  output logic chan_a,
  output logic [7:0] data_in,
  output logic rd_pulse,
  output logic [7:0] rd_val
);
  // idle bus at time zero
  initial begin
    {chip_sel_n, rd_n, wr_n, data_sel, chan_a, rd_pulse} = 6'h38;
    data_in = 8'h00;
  end
  // one bus cycle; cs drops with the strobe so it is never late
  task automatic xfer(input logic cs, input logic rd, input logic wr, input logic ds, input logic ca,
                      input logic [7:0] d);
    @(posedge clk) #2;
    {data_sel, chan_a} = {ds, ca};
    data_in = d;
    @(posedge clk) #2;
    {chip_sel_n, rd_n, wr_n} = {~cs, ~rd, ~wr};
    repeat (8) @(posedge clk);
    rd_val = data_out;
    #2;
    rd_pulse = cs & rd & ~wr;
    {chip_sel_n, rd_n, wr_n} = 3'h7;
    data_in = ~data_in; // released lines do not keep the byte
    @(posedge clk) #2;
    rd_pulse = 1'b0;
    repeat (6) @(posedge clk);
    #2;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ack_n = 1'b1;
  logic enh = 1'b1;
  logic [7:0] pend, vst, st_a, st_b, rx_a, rx_b;
  shp_pkg::shp_frame_s fr_a, fr_b;
  logic cs_n, rd_n, wr_n, ds, ca, rdp, oe, txw, txa, rxr, rxa, hwr, busy;
  logic [7:0] din, dout, rdv, pfl, txd, svec, mic, fopt;
  logic [127:0] wa;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] lf = 32'h69b9ba6e;
  logic [8:0] tx_q[$];
  logic rx_q[$];
  logic [7:0] rd_q[$];
  always #12.5 clk = ~clk;
  shp_host_model u_host (.clk(clk), .data_out(dout), .chip_sel_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .data_sel(ds), .chan_a(ca), .data_in(din), .rd_pulse(rdp), .rd_val(rdv));
  shp_host_port u_dut (.clk(clk), .resetn(resetn), .clk_en(1'b1), .chip_sel_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .data_sel(ds), .chan_a(ca), .irq_ack_n(ack_n), .enhanced_mode(enh), .data_in(din), .data_out(dout),
    .data_oe(oe), .pending_src(pend), .vector_status(vst), .status_a(st_a), .status_b(st_b), .rx_data_a(rx_a),
    .rx_data_b(rx_b), .frame_a(fr_a), .frame_b(fr_b), .pending_flags(pfl), .tx_data(txd), .tx_write(txw),
    .tx_chan_a(txa), .rx_read(rxr), .rx_chan_a(rxa), .hw_reset(hwr), .shared_vector_reg(svec),
    .master_irq_control(mic), .frame_option_a(fopt), .frame_option_b(), .wregs_a(wa), .wregs_b(), .busy(busy));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic d_s, input logic c_a, input logic [7:0] d);
    if (d_s) tx_q.push_back({c_a, d});
    u_host.xfer(1'b1, 1'b0, 1'b1, d_s, c_a, d);
  endtask
  task automatic rd(input logic d_s, input logic c_a, input logic [7:0] e);
    rd_q.push_back(e);
    if (d_s) rx_q.push_back(c_a);
    u_host.xfer(1'b1, 1'b1, 1'b0, d_s, c_a, 8'h00);
  endtask
  // pointer write, point high code for the upper eight
  task automatic pt(input logic c_a, input logic [3:0] idx);
    u_host.xfer(1'b1, 1'b0, 1'b1, 1'b0, c_a, {2'b00, 2'b00, idx[3], idx[2:0]});
  endtask
  // scoreboard: oldest note against each result as it shows
  always @(posedge clk) begin
    if (txw) chk("tx", tx_q.size() ? tx_q.pop_front() : 9'h1ff, {txa, txd});
    if (rxr) chk("rx", {8'h00, rx_q.size() ? rx_q.pop_front() : 1'bx}, {8'h00, rxa});
    if (rdp) chk("read", {1'b0, rd_q.size() ? rd_q.pop_front() : 8'hxx}, {1'b0, rdv});
  end
  // hang guard, about five times the roughly 750 cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    {st_a, st_b, rx_a, rx_b} = lf;
    lf = nxt(lf);
    {pend, vst, fr_a} = lf ^ 32'h5a5a5a5a;
    fr_b = lf[15:0];
    repeat (16) @(posedge clk);
    #2 resetn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      lf = nxt(lf);
      wr(1'b1, lf[8], lf[7:0] & 8'h7f);
      rd(1'b1, lf[9], lf[9] ? rx_a : rx_b);
    end
    pt(1'b1, 4'hc);
    wr(1'b0, 1'b1, lf[23:16]);
    chk("baud", {1'b0, lf[23:16]}, {1'b0, wa[12*8 +: 8]});
    pt(1'b1, 4'hc);
    rd(1'b0, 1'b1, lf[23:16]);
    rd(1'b0, 1'b1, st_a);
    pt(1'b0, 4'h2);
    wr(1'b0, 1'b0, 8'h3c);
    chk("vector", 9'h03c, {1'b0, svec});
    pt(1'b1, 4'h2);
    rd(1'b0, 1'b1, 8'h3c);
    pt(1'b0, 4'h2);
    rd(1'b0, 1'b0, vst);
    pt(1'b1, 4'h9);
    wr(1'b0, 1'b1, 8'ha5);
    chk("master", 9'h0a5, {1'b0, mic});
    chk("pending", {1'b0, pend}, {1'b0, pfl});
    pt(1'b1, 4'h3);
    rd(1'b0, 1'b1, pend);
    pt(1'b0, 4'h3);
    rd(1'b0, 1'b0, 8'h00);
    pt(1'b0, 4'hd);
    wr(1'b0, 1'b0, lf[31:24]);
    pt(1'b0, 4'hd);
    rd(1'b0, 1'b0, lf[31:24]);
    pt(1'b1, 4'h6);
    rd(1'b0, 1'b1, fr_a.count[7:0]);
    pt(1'b1, 4'h7);
    rd(1'b0, 1'b1, {fr_a.status, fr_a.count[13:8]});
    // enable the option copy, then write it through index 7
    pt(1'b1, 4'hf);
    wr(1'b0, 1'b1, 8'h01);
    pt(1'b1, 4'h7);
    wr(1'b0, 1'b1, lf[15:8]);
    chk("option", {1'b0, lf[15:8]}, {1'b0, fopt});
    enh = 1'b0;
    pt(1'b1, 4'h6);
    rd(1'b0, 1'b1, st_a);
    u_host.xfer(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h11);
    wr(1'b1, 1'b0, 8'h22);
    ack_n = 1'b0;
    u_host.xfer(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h33);
    ack_n = 1'b1;
    fork
      u_host.xfer(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h00);
      begin
        repeat (7) @(posedge clk);
        chk("hw_reset", 9'h001, {8'h00, hwr});
      end
    join
    chk("left", 9'h000, 9'(tx_q.size() + rx_q.size() + rd_q.size()));
    close_out();
  end
endmodule
`default_nettype wire
